/* File: hw/tcc_top.sv */
// timer capture/compare unit with its 16-bit timer and wishbone registers
//
// What this block does
// - a selected capture edge copies the 16-bit timer and raises that input's flag.
// - each capture input triggers on rising, falling or either edge.
// - capture inputs sampled at S1P1; timer latched at end of that cycle.
// - the four capture flags live in the timer interrupt flag register.
// - after each timer increment the new value is checked against three compares.
// - a compare match sets its flag at end of the cycle after the match.
// - compare 0 match sets port bits 0-5 enabled in the set mask.
// - compare 1 match clears port bits 0-5 enabled in the reset/toggle mask.
// - port bits with reset/toggle enable 0 ignore compare 1 and 2 matches.
// - compare 2 match toggles port bits 6 and 7 when enabled.
// - toggles follow two state flops, not the port latch value.
// - the first toggle after reset sets the port latch.
// - toggle state flops read as bits 6-7 of the set mask; 1 means next sets.
// - the three compare registers clear on chip reset.
// - match changes reach the pin at S5 next cycle; writes at next S1.
// - a hardware port change beats a software write in the same cycle.
// - a set and a reset of one latch together leave it cleared.
// - nine flags: eight in the flag register, byte overflow in control bit 4.
// - capture flags 0,1 set in S4, flags 2,3 in S6 of the capture cycle.
// - compare flags set in S6 after the match, visible two cycles on.
// - word and byte overflow flags set in S6 of the overflow cycle.
// - each priority bit set gives its source high priority.
// - the timer is not loadable; cleared by reset or enabled external edge.
//
// Chosen here: the address map and the Wishbone interface to the registers.
`default_nettype none
`include "tcc_defs.svh"

module tcc_top
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // wishbone slave
    input wire tcc_wb_req_type i_wb,
    output tcc_wb_rsp_type o_wb,
    // timer increment strobe from the prescaler, same clock
    input wire logic i_timer_inc,
    // pins
    input wire logic [3:0] i_capture_input,
    input wire logic i_timer_ext_reset_input,
    output logic [7:0] o_output_port_bit,
    // to the interrupt controller
    output logic [7:0] o_timer_irq_flags,
    output logic o_byte_overflow_flag,
    output logic [7:0] o_timer_irq_priority
);

    // ****************************************
    // state
    // ****************************************
    tcc_phase_type phase_q;
    tcc_phase_type phase_d;
    logic [15:0] timer_q;
    logic inc_pend_q;
    logic fresh_q;
    logic [3:0] cap_sync1_q;
    logic [3:0] cap_sync2_q;
    logic [3:0] cap_samp_q;
    logic [3:0] cap_prev_q;
    logic [2:0] ext_sync_q;
    logic [15:0] cap_q [`TCC_NUM_CAP];
    logic [15:0] cmp_q [`TCC_NUM_CMP];
    logic [2:0] match_q;
    logic [7:0] flags_q;
    logic [7:0] ctrl_q;
    logic [7:0] edge_q;
    logic [5:0] seten_q;
    logic [7:0] rten_q;
    logic [7:0] prio_q;
    logic [7:0] port_q;
    logic [1:0] tog_q;
    logic [7:0] hw_mask_q;
    logic sw_pend_q;
    logic [7:0] sw_data_q;
    logic ack_q;
    logic [31:0] rdat_q;

    // ****************************************
    // machine cycle sequencer
    // ****************************************
    wire logic at_s4 = (phase_q == TCC_S4);
    wire logic at_s5 = (phase_q == TCC_S5);
    wire logic at_s6 = (phase_q == TCC_S6);

    // next state of the six-state cycle
    always_comb begin
        case (phase_q)
            TCC_S1: phase_d = TCC_S2;
            TCC_S2: phase_d = TCC_S3;
            TCC_S3: phase_d = TCC_S4;
            TCC_S4: phase_d = TCC_S5;
            TCC_S5: phase_d = TCC_S6;
            TCC_S6: phase_d = TCC_S1;
            default: phase_d = TCC_S1;
        endcase
    end

    // sequencer register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_q <= TCC_S1;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ****************************************
    // bus decode
    // ****************************************
    wire logic bus_req = i_wb.cyc & i_wb.stb & ~ack_q;
    wire logic [4:0] bus_idx = i_wb.adr[6:2];
    wire logic bus_hit = (i_wb.adr[7] == 1'b0) && (bus_idx < `TCC_IDX_COUNT);
    // unmapped writes are dropped, so a high address never aliases onto the flags
    wire logic bus_wr = bus_req & i_wb.we & i_wb.sel[0] & bus_hit;
    wire logic [7:0] bus_byte = i_wb.dat[7:0];
    wire logic wr_flags = bus_wr && (bus_idx == `TCC_IDX_FLAGS);
    wire logic wr_ctrl = bus_wr && (bus_idx == `TCC_IDX_CTRL);
    wire logic wr_edge = bus_wr && (bus_idx == `TCC_IDX_EDGE);
    wire logic wr_seten = bus_wr && (bus_idx == `TCC_IDX_SETEN);
    wire logic wr_rten = bus_wr && (bus_idx == `TCC_IDX_RTEN);
    wire logic wr_prio = bus_wr && (bus_idx == `TCC_IDX_PRIO);
    wire logic wr_port = bus_wr && (bus_idx == `TCC_IDX_PORT);

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_sync1_q <= 4'h0;
            cap_sync2_q <= 4'h0;
            ext_sync_q <= 3'h0;
        end else begin
            cap_sync1_q <= i_capture_input;
            cap_sync2_q <= cap_sync1_q;
            ext_sync_q <= {ext_sync_q[1:0], i_timer_ext_reset_input};
        end
    end

    // ****************************************
    // timer
    // ****************************************
    wire logic ext_rst_evt = ext_sync_q[1] & ~ext_sync_q[2] & ctrl_q[`TCC_CTRL_EXT_RST_EN];
    wire logic inc_now = at_s6 & (inc_pend_q | i_timer_inc);
    wire logic byte_ovf = inc_now && (timer_q[7:0] == `TCC_BYTE_ONES);
    wire logic word_ovf = inc_now && (timer_q == `TCC_WORD_ONES);

    // count at most once per machine cycle, at its end, when an increment strobe is pending; no load path exists
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_q <= `TCC_WORD_ZERO;
            inc_pend_q <= 1'b0;
            fresh_q <= 1'b0;
        end else if (ext_rst_evt) begin
            timer_q <= `TCC_WORD_ZERO;
            inc_pend_q <= 1'b0;
            fresh_q <= 1'b0;
        end else begin
            inc_pend_q <= ~at_s6 & (inc_pend_q | i_timer_inc);
            if (inc_now) begin
                timer_q <= timer_q + 16'h0001;
            end
            if (at_s6) begin
                fresh_q <= inc_now;
            end
        end
    end

    // ****************************************
    // capture
    // ****************************************
    logic [3:0] cap_hit;

    // sample pins once per cycle at S1 edge
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_samp_q <= 4'h0;
            cap_prev_q <= 4'h0;
        end else if (at_s6) begin
            cap_samp_q <= cap_sync2_q;
            cap_prev_q <= cap_samp_q;
        end
    end

    // per input edge select and capture latch
    generate
        for (genvar gi = 0; gi < `TCC_NUM_CAP; gi++) begin : g_cap
            wire logic rise = cap_samp_q[gi] & ~cap_prev_q[gi];
            wire logic fall = ~cap_samp_q[gi] & cap_prev_q[gi];
            assign cap_hit[gi] = (rise & edge_q[2 * gi + `TCC_EDGE_RISE]) |
                                 (fall & edge_q[2 * gi + `TCC_EDGE_FALL]);

            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cap_q[gi] <= `TCC_WORD_ZERO;
                end else if (at_s6 && cap_hit[gi]) begin
                    cap_q[gi] <= timer_q;
                end
            end
        end
    endgenerate

    // ****************************************
    // compare
    // ****************************************
    logic [2:0] match_now;

    // equality against the freshly incremented value
    generate
        for (genvar gc = 0; gc < `TCC_NUM_CMP; gc++) begin : g_cmp
            assign match_now[gc] = fresh_q && (timer_q == cmp_q[gc]);

            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cmp_q[gc] <= `TCC_WORD_ZERO;
                end else if (bus_wr && (bus_idx == `TCC_IDX_CMP_BASE + 5'(2 * gc))) begin
                    cmp_q[gc][7:0] <= bus_byte;
                end else if (bus_wr && (bus_idx == `TCC_IDX_CMP_BASE + 5'(2 * gc + 1))) begin
                    cmp_q[gc][15:8] <= bus_byte;
                end
            end
        end
    endgenerate

    // hold match results through the following cycle
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            match_q <= 3'h0;
        end else if (at_s6) begin
            match_q <= match_now;
        end
    end

    // ****************************************
    // port latch actions
    // ****************************************
    wire logic [7:0] set_cmp = match_q[0] ? {2'h0, seten_q} : 8'h00;
    wire logic [7:0] rst_cmp = match_q[1] ? {2'h0, rten_q[5:0]} : 8'h00;
    wire logic [1:0] tog_go = {2{match_q[2]}} & rten_q[7:6];
    wire logic [7:0] set_all = set_cmp | {tog_go & tog_q, 6'h00};
    wire logic [7:0] rst_all = rst_cmp | {tog_go & ~tog_q, 6'h00};
    wire logic [7:0] port_hw = (port_q | set_all) & ~rst_all;
    wire logic [7:0] hw_mask = set_all | rst_all;
    wire logic [7:0] port_sw = (port_q & hw_mask_q) | (sw_data_q & ~hw_mask_q);

    // hardware change at S5, software write at next cycle start
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_q <= `TCC_BYTE_ZERO;
            tog_q <= `TCC_TOG_RESET;
            hw_mask_q <= `TCC_BYTE_ZERO;
        end else if (at_s5) begin
            port_q <= port_hw;
            tog_q <= tog_q ^ tog_go;
            hw_mask_q <= hw_mask;
        end else if (at_s6) begin
            if (sw_pend_q) begin
                port_q <= port_sw;
            end
            hw_mask_q <= `TCC_BYTE_ZERO;
        end
    end

    // pending software port write
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sw_pend_q <= 1'b0;
            sw_data_q <= `TCC_BYTE_ZERO;
        end else if (wr_port) begin
            sw_pend_q <= 1'b1;
            sw_data_q <= bus_byte;
        end else if (at_s6) begin
            sw_pend_q <= 1'b0;
        end
    end

    // ****************************************
    // interrupt flags (set beats clear)
    // ****************************************
    wire logic [7:0] flag_set = {
        at_s6 & word_ovf,
        {3{at_s6}} & match_q,
        {2{at_s6}} & cap_hit[3:2],
        {2{at_s4}} & cap_hit[1:0]
    };
    wire logic [7:0] flags_d = (wr_flags ? bus_byte : flags_q) | flag_set;
    wire logic ctrl_ovf = at_s6 & byte_ovf;

    // flag and control registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags_q <= `TCC_BYTE_ZERO;
            ctrl_q <= `TCC_BYTE_ZERO;
        end else begin
            flags_q <= flags_d;
            if (wr_ctrl) begin
                ctrl_q <= bus_byte;
            end
            if (ctrl_ovf) begin
                ctrl_q[`TCC_CTRL_BYTE_OVF] <= 1'b1;
            end
        end
    end

    // configuration registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            edge_q <= `TCC_BYTE_ZERO;
            seten_q <= 6'h00;
            rten_q <= `TCC_BYTE_ZERO;
            prio_q <= `TCC_BYTE_ZERO;
        end else begin
            if (wr_edge) begin
                edge_q <= bus_byte;
            end
            if (wr_seten) begin
                seten_q <= bus_byte[`TCC_SET_BITS-1:0];
            end
            if (wr_rten) begin
                rten_q <= bus_byte;
            end
            if (wr_prio) begin
                prio_q <= bus_byte;
            end
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    logic [7:0] rd_tab [`TCC_IDX_COUNT];
    assign rd_tab[`TCC_IDX_FLAGS] = flags_q;
    assign rd_tab[`TCC_IDX_CTRL] = ctrl_q;
    assign rd_tab[`TCC_IDX_EDGE] = edge_q;
    assign rd_tab[`TCC_IDX_SETEN] = {tog_q, seten_q};
    assign rd_tab[`TCC_IDX_RTEN] = rten_q;
    assign rd_tab[`TCC_IDX_PRIO] = prio_q;
    assign rd_tab[`TCC_IDX_PORT] = port_q;
    assign rd_tab[`TCC_IDX_TMR_LO] = timer_q[7:0];
    assign rd_tab[`TCC_IDX_TMR_HI] = timer_q[15:8];

    // capture and compare halves
    generate
        for (genvar gr = 0; gr < `TCC_NUM_CAP; gr++) begin : g_rcap
            assign rd_tab[`TCC_IDX_CAP_BASE + 2 * gr] = cap_q[gr][7:0];
            assign rd_tab[`TCC_IDX_CAP_BASE + 2 * gr + 1] = cap_q[gr][15:8];
        end
        for (genvar gm = 0; gm < `TCC_NUM_CMP; gm++) begin : g_rcmp
            assign rd_tab[`TCC_IDX_CMP_BASE + 2 * gm] = cmp_q[gm][7:0];
            assign rd_tab[`TCC_IDX_CMP_BASE + 2 * gm + 1] = cmp_q[gm][15:8];
        end
    endgenerate

    wire logic [7:0] rd_byte = bus_hit ? rd_tab[bus_idx] : `TCC_BYTE_ZERO;

    // one-cycle answer, unmapped reads zero
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            rdat_q <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_wb.ack = ack_q;
    assign o_wb.dat = rdat_q;
    assign o_output_port_bit = port_q;
    assign o_timer_irq_flags = flags_q;
    assign o_byte_overflow_flag = ctrl_q[`TCC_CTRL_BYTE_OVF];
    assign o_timer_irq_priority = prio_q;

endmodule : tcc_top

`default_nettype wire

/* File: hw/tcc_defs.svh */
// constants for the timer capture/compare unit
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define TCC_IDX_FLAGS 5'h00
`define TCC_IDX_CTRL 5'h01
`define TCC_IDX_EDGE 5'h02
`define TCC_IDX_SETEN 5'h03
`define TCC_IDX_RTEN 5'h04
`define TCC_IDX_PRIO 5'h05
`define TCC_IDX_PORT 5'h06
`define TCC_IDX_TMR_LO 5'h07
`define TCC_IDX_TMR_HI 5'h08
`define TCC_IDX_CAP_BASE 5'h09
`define TCC_IDX_CMP_BASE 5'h11
`define TCC_IDX_COUNT 5'h17

// ****************************************
// field positions
// ****************************************
`define TCC_FLAG_CMP_LSB 4
`define TCC_FLAG_WORD_OVF 7
`define TCC_CTRL_BYTE_OVF 4
`define TCC_CTRL_EXT_RST_EN 5
`define TCC_EDGE_RISE 0
`define TCC_EDGE_FALL 1

// ****************************************
// sizes and reset values
// ****************************************
`define TCC_NUM_CAP 4
`define TCC_NUM_CMP 3
`define TCC_SET_BITS 6
`define TCC_BYTE_ZERO 8'h00
`define TCC_WORD_ZERO 16'h0000
`define TCC_BYTE_ONES 8'hFF
`define TCC_WORD_ONES 16'hFFFF
`define TCC_TOG_RESET 2'h3

`endif

/* File: hw/tcc_pkg.sv */
// types shared by the timer capture/compare unit
`default_nettype none

package tcc_pkg;

    // ****************************************
    // machine cycle states, one clock each
    // ****************************************
    typedef enum logic [2:0] {
        TCC_S1 = 3'b000,
        TCC_S2 = 3'b001,
        TCC_S3 = 3'b010,
        TCC_S4 = 3'b011,
        TCC_S5 = 3'b100,
        TCC_S6 = 3'b101
    } tcc_phase_type;

    // ****************************************
    // wishbone request and answer
    // ****************************************
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } tcc_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } tcc_wb_rsp_type;

endpackage : tcc_pkg

`default_nettype wire

/* File: verif/tcc_top_sva.sv */
// assertion checker for the timer capture/compare unit
`default_nettype none

module tcc_top_sva
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // register bus
    input wire tcc_wb_req_type i_wb,
    input wire tcc_wb_rsp_type o_wb,
    // unit outputs
    input wire logic [7:0] o_output_port_bit,
    input wire logic [7:0] o_timer_irq_flags,
    input wire logic o_byte_overflow_flag,
    input wire logic [7:0] o_timer_irq_priority
);
    logic [2:0] ph_q;

    // bus request decode
    wire logic take = i_wb.cyc & i_wb.stb & ~o_wb.ack;
    wire logic wr = take & i_wb.we & i_wb.sel[0];
    wire logic wr_flags = wr & (i_wb.adr == 8'h00);
    wire logic wr_ctrl = wr & (i_wb.adr == 8'h04);
    wire logic wr_prio = wr & (i_wb.adr == 8'h14);

    // machine cycle state, S1 after reset
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) ph_q <= 3'h0;
        else ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    property p_ack_resp;
        take |=> o_wb.ack;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
    property p_ack_once;
        o_wb.ack |=> !o_wb.ack;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_rd_upper;
        o_wb.ack |-> (o_wb.dat[31:8] == 24'h000000);
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    property p_cap01_rise;
        (|(o_timer_irq_flags[1:0] & ~$past(o_timer_irq_flags[1:0]))) && !$past(wr_flags)
            |-> $past(ph_q) == 3'h3;
    endproperty
    a_cap01_rise: assert property (p_cap01_rise) else $error("capture flag 0/1 off S4");
    property p_s6_rise;
        (|(o_timer_irq_flags[7:2] & ~$past(o_timer_irq_flags[7:2]))) && !$past(wr_flags)
            |-> $past(ph_q) == 3'h5;
    endproperty
    a_s6_rise: assert property (p_s6_rise) else $error("flag set off S6");
    property p_bovf_rise;
        $rose(o_byte_overflow_flag) && !$past(wr_ctrl) |-> $past(ph_q) == 3'h5;
    endproperty
    a_bovf_rise: assert property (p_bovf_rise) else $error("byte overflow off S6");
    property p_flag_hold;
        (|($past(o_timer_irq_flags) & ~o_timer_irq_flags)) || $fell(o_byte_overflow_flag)
            |-> $past(wr_flags) || $past(wr_ctrl);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware");
    property p_port_slot;
        $changed(o_output_port_bit) |-> $past(ph_q) inside {3'h4, 3'h5};
    endproperty
    a_port_slot: assert property (p_port_slot) else $error("port changed off S5/S6");
    property p_prio_wr;
        $changed(o_timer_irq_priority) |-> $past(wr_prio);
    endproperty
    a_prio_wr: assert property (p_prio_wr) else $error("priority changed unasked");
endmodule : tcc_top_sva

`default_nettype wire

/* File: verif/tcc_pins.sv */
// pin-side model driving the capture pins and the timer reset pin
`default_nettype none

module tcc_pins (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // wanted levels: 3:0 capture pins, 4 timer reset pin
    input wire logic [4:0] i_want,
    // pins
    output logic [3:0] o_capture_input,
    output logic o_timer_ext_reset_input
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 14;
    logic [4:0] lvl_q;
    int hold_q;

    // each new level stands over two machine cycles so it is sampled
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvl_q <= 5'h00;
            hold_q <= 0;
        end else if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end else if (i_want != lvl_q) begin
            lvl_q <= i_want;
            hold_q <= HOLD;
        end
    end
    assign o_capture_input = lvl_q[3:0];
    assign o_timer_ext_reset_input = lvl_q[4];
endmodule : tcc_pins

`default_nettype wire

/* File: verif/tcc_top_tb.sv */
// self-checking bench for the timer capture/compare unit
`default_nettype none

module tcc_top_tb import tcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk;
    logic i_rst_n;
    tcc_wb_req_type i_wb;
    tcc_wb_rsp_type o_wb;
    logic i_timer_inc;
    logic [4:0] want;
    logic [3:0] cap_pins;
    logic ext_pin;
    logic [7:0] rd;
    logic [7:0] p;
    logic [15:0] tmr;
    logic [15:0] v;
    logic [15:0] q_exp[$];
    logic [7:0] port_o;
    logic [7:0] flags_o;
    logic bovf_o;
    logic [7:0] prio_o;
    int errors;
    int checks;

    tcc_top i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_wb(i_wb), .o_wb(o_wb),
        .i_timer_inc(i_timer_inc), .i_capture_input(cap_pins),
        .i_timer_ext_reset_input(ext_pin), .o_output_port_bit(port_o),
        .o_timer_irq_flags(flags_o), .o_byte_overflow_flag(bovf_o),
        .o_timer_irq_priority(prio_o));
    tcc_pins i_pins (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_want(want),
        .o_capture_input(cap_pins), .o_timer_ext_reset_input(ext_pin));

    // clock
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    // compare each bus answer with the oldest note {mask, value}
    always @(posedge i_core_clk) begin
        if (o_wb.ack === 1'b1 && q_exp.size() > 0) begin
            logic [15:0] note_v;
            note_v = q_exp.pop_front();
            if (note_v[15:8] != 8'h00) begin
                checks++;
                if ((o_wb.dat[7:0] & note_v[15:8]) !== note_v[7:0]) begin
                    errors++;
                    $display("ERROR %0t read %h expected %h", $time, o_wb.dat[7:0], note_v[7:0]);
                end
            end
        end
    end

    // one classic cycle; the note goes to the queue
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
            input logic [15:0] note);
        q_exp.push_back(note);
        i_wb <= {1'b1, 1'b1, we, adr, 4'hF, 24'h000000, wd};
        // wait for ack as long as it takes; only the watchdog ends a hang
        do begin
            @(posedge i_core_clk);
        end while (o_wb.ack !== 1'b1);
        rd = o_wb.dat[7:0];
        i_wb <= '0;
        @(posedge i_core_clk);
    endtask : bus

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        bus(1'b1, adr, d, 16'h0000);
    endtask : wr

    task automatic chk(input logic [7:0] adr, input logic [7:0] m, input logic [7:0] e);
        bus(1'b0, adr, 8'h00, {m, e & m});
    endtask : chk

    // direct look at an output pin against its expected level
    task automatic pin(input logic [7:0] got, input logic [7:0] e);
        checks++;
        if (got !== e) begin
            errors++;
            $display("ERROR %0t pin %h expected %h", $time, got, e);
        end
    endtask : pin

    task automatic rtime();
        bus(1'b0, 8'h1C, 8'h00, 16'h0000);
        tmr[7:0] = rd;
        bus(1'b0, 8'h20, 8'h00, 16'h0000);
        tmr[15:8] = rd;
    endtask : rtime

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // watchdog
    initial begin
        #(10 * 6000);
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        report_and_stop();
    end

    // main sequence
    initial begin
        i_rst_n = 1'b0;
        i_wb = '0;
        i_timer_inc = 1'b0;
        want = 5'h00;
        errors = 0;
        checks = 0;
        void'($urandom(24205));
        repeat (2) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        i_timer_inc <= 1'b1;
        @(posedge i_core_clk);
        chk(8'h0C, 8'hFF, 8'hC0);
        chk(8'h00, 8'hFF, 8'h00);
        for (int i = 0; i < 6; i++) chk(8'h44 + 8'(4 * i), 8'hFF, 8'h00);
        $display("test reset values done");
        p = 8'($urandom());
        wr(8'h14, p);
        chk(8'h14, 8'hFF, p);
        pin(prio_o, p);
        wr(8'h80, 8'hA5);
        chk(8'h80, 8'hFF, 8'h00);
        chk(8'h00, 8'hFF, 8'h00);
        pin(flags_o, 8'h00);
        chk(8'h5C, 8'hFF, 8'h00);
        $display("test bus done");
        // set, reset and toggle on the same and later matches
        wr(8'h18, 8'h2B);
        wr(8'h0C, 8'h15);
        wr(8'h10, 8'hCB);
        rtime();
        for (int i = 0; i < 3; i++) begin
            v = tmr + 16'(i == 2 ? 14 : 10);
            wr(8'h44 + 8'(8 * i), v[7:0]);
            wr(8'h48 + 8'(8 * i), v[15:8]);
        end
        repeat (6 * 18) @(posedge i_core_clk);
        chk(8'h18, 8'hFF, 8'hF4);
        chk(8'h00, 8'h70, 8'h70);
        chk(8'h0C, 8'hFF, 8'h15);
        pin(port_o, 8'hF4);
        pin(flags_o & 8'h70, 8'h70);
        $display("test compare done");
        // software clears the toggled bits; next toggle still resets
        wr(8'h18, 8'h34);
        rtime();
        v = tmr + 16'h0008;
        wr(8'h54, v[7:0]);
        wr(8'h58, v[15:8]);
        repeat (6 * 11) @(posedge i_core_clk);
        chk(8'h18, 8'hFF, 8'h34);
        chk(8'h0C, 8'hFF, 8'hD5);
        chk(8'h00, 8'h70, 8'h70);
        wr(8'h00, 8'h00);
        chk(8'h00, 8'hFF, 8'h00);
        $display("test toggle done");
        // capture with the timer held still: rise, fall, both
        i_timer_inc <= 1'b0;
        wr(8'h08, 8'h79);
        repeat (8) @(posedge i_core_clk);
        rtime();
        want <= 5'h0F;
        repeat (40) @(posedge i_core_clk);
        chk(8'h00, 8'h0F, 8'h0D);
        want <= 5'h00;
        repeat (40) @(posedge i_core_clk);
        chk(8'h00, 8'h0F, 8'h0F);
        pin(flags_o & 8'h0F, 8'h0F);
        for (int i = 0; i < 8; i++) chk(8'h24 + 8'(4 * i), 8'hFF, i[0] ? tmr[15:8] : tmr[7:0]);
        $display("test capture done");
        // external timer reset, then byte overflow
        wr(8'h04, 8'h20);
        want <= 5'h10;
        repeat (40) @(posedge i_core_clk);
        chk(8'h1C, 8'hFF, 8'h00);
        chk(8'h20, 8'hFF, 8'h00);
        i_timer_inc <= 1'b1;
        repeat (6 * 258) @(posedge i_core_clk);
        chk(8'h04, 8'hFF, 8'h30);
        chk(8'h00, 8'h80, 8'h00);
        pin({7'h00, bovf_o}, 8'h01);
        $display("test overflow done");
        report_and_stop();
    end
endmodule : tcc_top_tb

bind tcc_top tcc_top_sva i_sva (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_wb(i_wb),
    .o_wb(o_wb),
    .o_output_port_bit(o_output_port_bit),
    .o_timer_irq_flags(o_timer_irq_flags),
    .o_byte_overflow_flag(o_byte_overflow_flag),
    .o_timer_irq_priority(o_timer_irq_priority)
);

`default_nettype wire
